// File: hdl/ddr_read_pkg.sv
package ddr_read_pkg;

  // Command codes carried on the link
  localparam logic [1:0] CMD_NOP = 2'h0;
  localparam logic [1:0] CMD_ACT = 2'h1;
  localparam logic [1:0] CMD_RD  = 2'h2;

  // Burst-length field of mode_register_zero
  localparam logic [1:0] BURST_EIGHT  = 2'h0;
  localparam logic [1:0] BURST_CHOICE = 2'h1;
  localparam logic [1:0] BURST_FOUR   = 2'h2;

  // Beat pairs per burst, one pair per command clock
  localparam int PAIRS_EIGHT = 4;
  localparam int PAIRS_FOUR  = 2;

  // Timing, in ns, in system clocks and in command clocks
  localparam int CLK_PERIOD_NS   = 100;
  localparam int LINK_PERIOD_NS  = 800;
  localparam int LINK_HALF       = LINK_PERIOD_NS / (2 * CLK_PERIOD_NS);
  localparam int GAP_OTHER_GROUP = 4;
  localparam int GAP_SAME_GROUP  = 5;
  localparam int GAP_ODD         = 5;
  localparam int FETCH_CLOCKS    = 4;
  localparam int CL_MIN          = 5;
  localparam int CL_MAX          = 24;

  // Data lane width
  localparam int DQ_W = 8;

  // Command word: bit 1:0 kind, 3:2 group, 5:4 bank, 8:6 column,
  // 9 burst_select_address_bit, 10 auto_close_address_bit
  typedef struct packed {
    logic       autoClose;
    logic       burstSel;
    logic [2:0] col;
    logic [1:0] bank;
    logic [1:0] group;
    logic [1:0] kind;
  } link_cmd_t;
  localparam int CMD_W = 11;

  // Mode word: 1:0 burst field, 2 long preamble, 7:3 CAS, 8 additive
  typedef struct packed {
    logic       alOn;
    logic [4:0] cl;
    logic       pre2;
    logic [1:0] burst;
  } mode_t;
  localparam int    MODE_W     = 9;
  localparam mode_t MODE_RESET = '{alOn: 1'b0, cl: 5'h0B, pre2: 1'b0,
                                   burst: 2'h0};

  // APB register map and status fields
  localparam logic [7:0] OFS_CFG  = 8'h00;
  localparam logic [7:0] OFS_CMD  = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_DATA = 8'h0C;
  localparam int STAT_PEND_BIT  = 0;
  localparam int STAT_COUNT_LSB = 8;

endpackage

// File: hdl/ddr_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ddr_link_if;
  // Controller to device
  logic                      cmdClk;
  ddr_read_pkg::link_cmd_t   cmdBus;
  ddr_read_pkg::mode_t       modeBus;
  // Device drive side of strobe and data
  logic                      strobeOut;
  logic                      strobeOe_n;
  logic [ddr_read_pkg::DQ_W-1:0] dqOut;
  logic                      dqOe_n;
  // Resolved bus as the controller sees it
  logic                      strobeWire;
  logic [ddr_read_pkg::DQ_W-1:0] dqWire;
  logic                      dqDriven;

  // Bus is pulled high when nobody drives it
  assign strobeWire = strobeOe_n ? 1'b1 : strobeOut;
  assign dqWire     = dqOe_n ? '1 : dqOut;
  assign dqDriven   = ~dqOe_n;

  modport ctrl (output cmdClk, cmdBus, modeBus,
                input  strobeWire, dqWire, dqDriven);
  modport dev  (input  cmdClk, cmdBus, modeBus,
                output strobeOut, strobeOe_n, dqOut, dqOe_n);
endinterface
`default_nettype wire

// File: hdl/ddr_read_device.sv
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Field 00 fixed eight; 01 per-command choice
// - Field 10 fixed chopped four beats
// - Select bit low chops, high gives eight
// - Plain read leaves bank open
// - Auto-close read precharges bank after the burst fetch
// - First data after additive plus CAS latency
// - Additive latency is zero or CAS minus one
// - Eight-beat reads four apart stream gaplessly
// - Chopped reads four apart leave slots idle
// - Spacing five, short preamble, leaves a gap
// - Long preamble: spacing six, never five
// - Preamble one or two clocks, same latency
// - Strobe alignment only while loop locked
// - Preamble drives strobe low from released
// - After postamble release strobe high undriven
// - One data beat per strobe edge
// - Mode register four bit picks preamble
// - Other group four clocks; same group longer
module ddr_read_device #(
  parameter int CL_MAX = ddr_read_pkg::CL_MAX,
  parameter int SLOTS  = 2 * CL_MAX + 2
) (
  // System
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Link to controller
  ddr_link_if.dev          link,
  // Device side status
  input  wire logic        dllLocked,
  output logic [15:0]      bankOpen
);

  // Refuse sizes the timeline cannot hold
  if (CL_MAX < ddr_read_pkg::CL_MIN || CL_MAX > 31 ||
      SLOTS < 2 * CL_MAX + 2) begin : g_bad_size
    $error("ddr_read_device: CL_MAX or SLOTS out of range");
  end

  // One command clock of the data timeline
  typedef struct packed {
    logic       valid;      // Beat pair due in this clock
    logic [1:0] pair;       // Pair index inside the burst
    logic [4:0] tag;        // Group and column, for the data
    logic       closeV;     // Bank closes at this clock
    logic [3:0] closeBank;  // Bank that closes
  } slot_t;

  // Everything that crosses in from the controller's side, plus loop lock
  typedef struct packed {
    logic                    lock;
    logic                    cclk;
    ddr_read_pkg::link_cmd_t cmd;
    ddr_read_pkg::mode_t     mode;
  } sync_t;

  // All state of the device end
  typedef struct packed {
    sync_t                       s1;        // First sync stage only
    sync_t                       s2;        // Usable synced copy
    logic                        clkPrev;   // For edge finding
    slot_t [SLOTS-1:0]           tl;        // Future clocks
    slot_t                       cur;       // Clock now on the bus
    logic [15:0]                 bankOpen;  // Open banks
    logic                        strobe;
    logic                        strobeOe_n;
    logic [ddr_read_pkg::DQ_W-1:0] dq;
    logic                        dqOe_n;
  } state_t;

  state_t q_r;
  state_t q_nxt;

  // Decoded helpers
  logic       rise;      // Command clock rising edge found
  logic       fall;      // Command clock falling edge found
  logic       chop;      // This read is four beats
  logic [2:0] pairs;     // Beat pairs for this read
  logic [6:0] rl;        // total_read_latency in clocks
  logic [6:0] al;        // additive_latency in clocks
  logic       clOk;      // CAS setting inside supported range
  logic [3:0] bankId;    // Group and bank of this command

  // Data beat: group, pair, odd half, column
  function automatic logic [7:0] beatData(slot_t s, logic odd);
    return {s.tag[4:3], s.pair, odd, s.tag[2:0]};
  endfunction

  // Strobe must already be low ahead of the next burst
  function automatic logic preambleDue(slot_t [SLOTS-1:0] t,
                                       logic pre2);
    return t[0].valid || (pre2 && t[1].valid);
  endfunction

  // Edges of the synced command clock
  assign rise = q_r.s2.cclk & ~q_r.clkPrev;
  assign fall = ~q_r.s2.cclk & q_r.clkPrev;

  // Burst length from mode field and select bit
  assign chop = (q_r.s2.mode.burst == ddr_read_pkg::BURST_FOUR) ||
                ((q_r.s2.mode.burst == ddr_read_pkg::BURST_CHOICE) &&
                 !q_r.s2.cmd.burstSel);
  assign pairs = chop ? 3'(ddr_read_pkg::PAIRS_FOUR)
                      : 3'(ddr_read_pkg::PAIRS_EIGHT);

  // Additive is either zero or one less than CAS
  assign al = q_r.s2.mode.alOn ? 7'(q_r.s2.mode.cl) - 7'h01
                               : 7'h00;
  assign rl = al + 7'(q_r.s2.mode.cl);
  assign clOk = (7'(q_r.s2.mode.cl) >= 7'(ddr_read_pkg::CL_MIN)) &&
                (7'(q_r.s2.mode.cl) <= 7'(CL_MAX));
  assign bankId = {q_r.s2.cmd.group, q_r.s2.cmd.bank};

  // Next-state logic
  always_comb begin
    q_nxt = q_r;
    // Two stages for every signal from the other side
    q_nxt.s1.lock = dllLocked;
    q_nxt.s1.cclk = link.cmdClk;
    q_nxt.s1.cmd  = link.cmdBus;
    q_nxt.s1.mode = link.modeBus;
    q_nxt.s2      = q_r.s1;
    q_nxt.clkPrev = q_r.s2.cclk;

    if (rise) begin
      // Advance the timeline by one command clock
      q_nxt.cur = q_r.tl[0];
      for (int i = 0; i < SLOTS - 1; i++) begin
        q_nxt.tl[i] = q_r.tl[i+1];
      end
      q_nxt.tl[SLOTS-1] = '0;
      // Precharge falls due once the fetch is over
      if (q_r.tl[0].closeV) begin
        q_nxt.bankOpen[q_r.tl[0].closeBank] = 1'b0;
      end

      // Opening a bank
      if (q_r.s2.cmd.kind == ddr_read_pkg::CMD_ACT) begin
        q_nxt.bankOpen[bankId] = 1'b1;
      end

      // A read plans its beats; refused while unlocked, since
      // no strobe alignment could be promised then
      if (q_r.s2.cmd.kind == ddr_read_pkg::CMD_RD && q_r.s2.lock &&
          clOk) begin
        for (int k = 0; k < ddr_read_pkg::PAIRS_EIGHT; k++) begin
          // Chopped reads leave the upper slots empty
          if (3'(k) < pairs) begin
            q_nxt.tl[rl + 7'(k) - 7'h01].valid = 1'b1;
            q_nxt.tl[rl + 7'(k) - 7'h01].pair  = 2'(k);
            q_nxt.tl[rl + 7'(k) - 7'h01].tag   =
              {q_r.s2.cmd.group, q_r.s2.cmd.col};
          end
        end
        // Plain read leaves the bank open; auto-close is queued
        // after the internal fetch of the burst
        if (q_r.s2.cmd.autoClose) begin
          q_nxt.tl[al + 7'(ddr_read_pkg::FETCH_CLOCKS) - 7'h01].closeV
            = 1'b1;
          q_nxt.tl[al + 7'(ddr_read_pkg::FETCH_CLOCKS) - 7'h01]
            .closeBank = bankId;
        end
      end

      // Rising half: even beat, preamble, postamble or release
      if (q_nxt.cur.valid) begin
        // Consecutive slots keep toggling with no gap
        q_nxt.strobe     = 1'b1;
        q_nxt.strobeOe_n = 1'b0;
        q_nxt.dq         = beatData(q_nxt.cur, 1'b0);
        q_nxt.dqOe_n     = 1'b0;
      end else if (preambleDue(q_nxt.tl, q_r.s2.mode.pre2)) begin
        // Empty slot before a burst stays low: gap, no release
        q_nxt.strobe     = 1'b0;
        q_nxt.strobeOe_n = 1'b0;
        q_nxt.dqOe_n     = 1'b1;
      end else if (q_r.cur.valid) begin
        // Postamble: half a clock low after the last beat
        q_nxt.strobe     = 1'b0;
        q_nxt.strobeOe_n = 1'b0;
        q_nxt.dqOe_n     = 1'b1;
      end else begin
        q_nxt.strobe     = 1'b1;
        q_nxt.strobeOe_n = 1'b1;
        q_nxt.dqOe_n     = 1'b1;
      end
    end else if (fall) begin
      // Falling half: odd beat, held preamble, or release
      if (q_r.cur.valid) begin
        q_nxt.strobe     = 1'b0;
        q_nxt.strobeOe_n = 1'b0;
        q_nxt.dq         = beatData(q_r.cur, 1'b1);
        q_nxt.dqOe_n     = 1'b0;
      end else if (preambleDue(q_r.tl, q_r.s2.mode.pre2)) begin
        // Preamble low set on the rising half is held here
        q_nxt.strobe     = 1'b0;
        q_nxt.strobeOe_n = 1'b0;
        q_nxt.dqOe_n     = 1'b1;
      end else begin
        // Bus handed back, pulled high
        q_nxt.strobe     = 1'b1;
        q_nxt.strobeOe_n = 1'b1;
        q_nxt.dqOe_n     = 1'b1;
      end
    end
  end

  // State register, synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_r            <= '0;
      q_r.strobe     <= 1'b1;
      q_r.strobeOe_n <= 1'b1;
      q_r.dqOe_n     <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Outputs straight from the state register
  assign link.strobeOut  = q_r.strobe;
  assign link.strobeOe_n = q_r.strobeOe_n;
  assign link.dqOut      = q_r.dq;
  assign link.dqOe_n     = q_r.dqOe_n;
  assign bankOpen        = q_r.bankOpen;

endmodule
`default_nettype wire

// File: hdl/ddr_read_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_read_ctrl #(
  parameter int LINK_HALF = ddr_read_pkg::LINK_HALF,
  parameter int GAP_SAME  = ddr_read_pkg::GAP_SAME_GROUP
) (
  // System
  input  wire logic        clk,
  input  wire logic        rst_n,
  // APB slave
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Link to device
  ddr_link_if.ctrl         link
);

  // Divider needs room for the device's synchronisers
  if (LINK_HALF < 3 || LINK_HALF > 255 ||
      GAP_SAME < ddr_read_pkg::GAP_OTHER_GROUP || GAP_SAME > 14)
  begin : g_bad_param
    $error("ddr_read_ctrl: LINK_HALF or GAP_SAME out of range");
  end

  // Strobe and data as sampled from the bus
  typedef struct packed {
    logic                          strobe;
    logic                          driven;
    logic [ddr_read_pkg::DQ_W-1:0] dq;
  } samp_t;

  // All state of the controller end
  typedef struct packed {
    logic [7:0]              div;        // Half-period counter
    logic                    linkClk;    // Command clock out
    ddr_read_pkg::mode_t     mode;       // Mode settings
    logic                    pend;       // Command waiting
    ddr_read_pkg::link_cmd_t hold;       // The waiting command
    ddr_read_pkg::link_cmd_t cmdOut;     // Command on the link
    logic [3:0]              gap;        // Clocks since last read
    logic [1:0]              lastGroup;  // Group of last read
    samp_t                   s1;         // First sync stage only
    samp_t                   s2;         // Usable synced copy
    logic                    s3Strobe;   // For edge finding
    logic [7:0]              beatCount;  // Beats captured
    logic [31:0]             dataWord;   // Last four beats
    logic [31:0]             prdata;
    logic                    pready;
    logic                    pslverr;
  } state_t;

  state_t q_r;
  state_t q_nxt;

  // Decoded helpers
  logic       tick;     // Half period over
  logic [3:0] gapInc;   // Gap counted up, saturating
  logic [3:0] need;     // Spacing this read needs
  logic       mayGo;    // Spacing rules met

  assign tick   = q_r.div == 8'(LINK_HALF - 1);
  assign gapInc = (q_r.gap == 4'hF) ? 4'hF : q_r.gap + 4'h1;
  // Same group takes the longer spacing
  assign need   = (q_r.hold.group == q_r.lastGroup) ? 4'(GAP_SAME)
                  : 4'(ddr_read_pkg::GAP_OTHER_GROUP);
  // Long preamble forbids the odd spacing
  assign mayGo  = (gapInc >= need) &&
                  !(q_r.mode.pre2 &&
                    gapInc == 4'(ddr_read_pkg::GAP_ODD));

  // Next-state logic
  always_comb begin
    q_nxt = q_r;

    // Command clock divider
    if (tick) begin
      q_nxt.div     = 8'h00;
      q_nxt.linkClk = ~q_r.linkClk;
    end else begin
      q_nxt.div = q_r.div + 8'h01;
    end

    // Commands change on the falling edge, device takes the rise
    if (tick && q_r.linkClk) begin
      q_nxt.cmdOut = '0;
      q_nxt.gap    = gapInc;
      if (q_r.pend && q_r.hold.kind != ddr_read_pkg::CMD_RD) begin
        q_nxt.cmdOut = q_r.hold;
        q_nxt.pend   = 1'b0;
      end else if (q_r.pend && mayGo) begin
        q_nxt.cmdOut    = q_r.hold;
        q_nxt.pend      = 1'b0;
        q_nxt.gap       = 4'h0;
        q_nxt.lastGroup = q_r.hold.group;
      end
    end

    // Capture one beat on each strobe edge while data is driven
    q_nxt.s1.strobe = link.strobeWire;
    q_nxt.s1.driven = link.dqDriven;
    q_nxt.s1.dq     = link.dqWire;
    q_nxt.s2        = q_r.s1;
    q_nxt.s3Strobe  = q_r.s2.strobe;
    if ((q_r.s2.strobe != q_r.s3Strobe) && q_r.s2.driven) begin
      q_nxt.dataWord  = {q_r.dataWord[23:0], q_r.s2.dq};
      q_nxt.beatCount = q_r.beatCount + 8'h01;
    end

    // APB: answer in the first access cycle unless stalled
    q_nxt.pready  = 1'b0;
    q_nxt.pslverr = 1'b0;
    if (psel && penable && q_r.pready) begin
      // Completing edge: only here does a write take effect
      if (pwrite && paddr == ddr_read_pkg::OFS_CFG) begin
        q_nxt.mode = ddr_read_pkg::mode_t'(
                       pwdata[ddr_read_pkg::MODE_W-1:0]);
      end else if (pwrite && paddr == ddr_read_pkg::OFS_CMD) begin
        q_nxt.hold = ddr_read_pkg::link_cmd_t'(
                       pwdata[ddr_read_pkg::CMD_W-1:0]);
        q_nxt.pend = 1'b1;
      end
    end else if (psel && !q_r.pready) begin
      q_nxt.prdata = 32'h0000_0000;
      q_nxt.pready = 1'b1;
      if (paddr == ddr_read_pkg::OFS_CFG) begin
        q_nxt.prdata[ddr_read_pkg::MODE_W-1:0] = q_r.mode;
      end else if (paddr == ddr_read_pkg::OFS_CMD) begin
        // A new command waits until the previous one is sent
        q_nxt.pready = !(pwrite && q_r.pend);
        q_nxt.prdata[ddr_read_pkg::CMD_W-1:0] = q_r.hold;
      end else if (paddr == ddr_read_pkg::OFS_STAT) begin
        q_nxt.prdata[ddr_read_pkg::STAT_PEND_BIT] = q_r.pend;
        q_nxt.prdata[ddr_read_pkg::STAT_COUNT_LSB +: 8] =
          q_r.beatCount;
      end else if (paddr == ddr_read_pkg::OFS_DATA) begin
        q_nxt.prdata = q_r.dataWord;
      end else begin
        // Unmapped offset answers with an error
        q_nxt.pslverr = 1'b1;
      end
    end
  end

  // State register, synchronous reset
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q_r      <= '0;
      q_r.mode <= ddr_read_pkg::MODE_RESET;
      q_r.gap  <= 4'hF;
    end else begin
      q_r <= q_nxt;
    end
  end

  // Outputs straight from the state register
  assign prdata       = q_r.prdata;
  assign pready       = q_r.pready;
  assign pslverr      = q_r.pslverr;
  assign link.cmdClk  = q_r.linkClk;
  assign link.cmdBus  = q_r.cmdOut;
  assign link.modeBus = q_r.mode;

endmodule
`default_nettype wire

// File: test/ddr_read_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module ddr_read_assertions (
  // Clock and reset
  input wire logic                          clk,
  input wire logic                          rst_n,
  // Link signals
  input wire logic                          cmdClk,
  input wire ddr_read_pkg::link_cmd_t       cmdBus,
  input wire ddr_read_pkg::mode_t           modeBus,
  input wire logic                          strobeOut,
  input wire logic                          strobeOe_n,
  input wire logic [ddr_read_pkg::DQ_W-1:0] dqOut,
  input wire logic                          dqOe_n,
  input wire logic                          strobeWire
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);

  ddr_read_pkg::link_cmd_t prevCmd_r; // Last command seen
  logic [7:0]              rdGap_r;   // Clocks since last read
  logic                    rdStart;   // New read on the bus

  assign rdStart = (cmdBus != prevCmd_r) &&
                   (cmdBus.kind == ddr_read_pkg::CMD_RD);

  // Gap saturates so long idle spells never wrap to a short one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prevCmd_r <= '0;
      rdGap_r   <= 8'hFF;
    end else begin
      prevCmd_r <= cmdBus;
      if (rdStart)
        rdGap_r <= 8'h01;
      else if (rdGap_r != 8'hFF)
        rdGap_r <= rdGap_r + 8'h01;
    end
  end

  idle_release_a: assert property (
    strobeOe_n |-> dqOe_n) else $error("data driven, strobe released");
  preamble_low_a: assert property (
    $fell(strobeOe_n) |-> !strobeOut) else $error("preamble not low");
  beat_hold_a: assert property (
    !dqOe_n && $past(dqOe_n) == 1'b0 && $stable(strobeOut)
    |-> $stable(dqOut)) else $error("data moved between edges");
  post_low_a: assert property (
    $rose(dqOe_n) |-> !strobeWire [*4]) else $error("postamble short");
  short_pre_a: assert property (
    $fell(strobeOe_n) && !modeBus.pre2 |-> !strobeWire [*8] ##1 strobeWire)
    else $error("one clock preamble wrong");
  long_pre_a: assert property (
    $fell(strobeOe_n) && modeBus.pre2
    |-> !strobeWire [*8] ##1 !strobeWire [*8] ##1 strobeWire)
    else $error("two clock preamble wrong");
  cmd_hold_a: assert property (
    $changed(cmdBus) |-> $fell(cmdClk) ##1 $stable(cmdBus) [*7])
    else $error("command not held a clock");
  read_spacing_a: assert property (
    rdStart |-> rdGap_r >= 8'h20) else $error("reads too close");
  long_gap_a: assert property (
    rdStart && modeBus.pre2 |-> !(rdGap_r inside {[8'h28:8'h2F]}))
    else $error("spacing five with long preamble");

  // Main scenarios reached
  cover property (rdStart && !cmdBus.burstSel);
  cover property ($fell(strobeOe_n) && modeBus.pre2);
  cover property (rdStart && rdGap_r == 8'h20);
endmodule
`default_nettype wire

// File: test/sdram_read_burst_sequencing_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sdram_read_burst_sequencing_tb;
  logic        clk, rst_n, dllLocked;  // System
  logic [15:0] bankOpen;               // Open bank map
  logic [7:0]  paddr;                  // APB master
  logic        psel, penable, pwrite, pready, pslverr;
  logic [31:0] pwdata, prdata;
  int          err_count, cmp_count;   // Scoreboard
  int          cyc, nRd, nOn, nOff;    // Event stamps from the link
  int          rdAt[4], onAt[4], offAt[4];
  logic [7:0]  expBeats;               // Beats captured so far
  ddr_read_pkg::link_cmd_t prevCmd;
  logic        prevDq;

  ddr_link_if link ();
  ddr_read_device u_ddr_read_device (.clk(clk), .rst_n(rst_n),
    .link(link.dev), .dllLocked(dllLocked), .bankOpen(bankOpen));
  ddr_read_ctrl u_ddr_read_ctrl (.clk(clk), .rst_n(rst_n), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link.ctrl));
  ddr_read_assertions u_ddr_read_assertions (.clk(clk), .rst_n(rst_n),
    .cmdClk(link.cmdClk), .cmdBus(link.cmdBus), .modeBus(link.modeBus),
    .strobeOut(link.strobeOut), .strobeOe_n(link.strobeOe_n),
    .dqOut(link.dqOut), .dqOe_n(link.dqOe_n), .strobeWire(link.strobeWire));

  initial clk = 1'b0;
  always #50 clk = ~clk;

  // Stamps read issues and data bus turn-on/off; cuts a hang short
  always @(posedge clk) begin
    cyc++;
    if (link.cmdBus !== prevCmd && link.cmdBus.kind === 2'h2) begin
      rdAt[nRd%4] = cyc;
      nRd++;
    end
    if (link.dqDriven === 1'b1 && prevDq !== 1'b1) begin
      onAt[nOn%4] = cyc;
      nOn++;
    end
    if (link.dqDriven !== 1'b1 && prevDq === 1'b1) begin
      offAt[nOff%4] = cyc;
      nOff++;
    end
    prevCmd = link.cmdBus;
    prevDq = link.dqDriven;
    if (cyc > 20000) begin
      err_count++;
      results();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; waits for pready however long the slave takes
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask

  // Mode word: burst field, long preamble, additive latency on, CAS 11
  function automatic logic [31:0] cfg(logic [1:0] b, logic p, logic al);
    return {23'h0, al, 5'h0B, p, b};
  endfunction

  function automatic logic [31:0] cmd(logic [1:0] k, logic [1:0] g,
                                      logic [1:0] b, logic s, logic ac);
    return {21'h0, ac, s, 3'h5, b, g, k};
  endfunction

  // Waits for the expected data bursts to end, bounded
  task automatic settle(input int offs);
    for (int i = 0; i < 1000 && nOff < offs; i++) @(posedge clk);
    repeat (8) @(posedge clk);
  endtask

  task automatic clr;
    nRd = 0;
    nOn = 0;
    nOff = 0;
  endtask

  // One read to an opened bank; judges latency, length, data, bank state
  task automatic runOne(input logic [31:0] c, input logic [1:0] g,
                        input logic s, ac, ch, input int rl);
    logic [31:0] q;
    logic        e;
    logic [1:0]  p;
    p = ch ? 2'h0 : 2'h2;
    wr(8'h00, c);
    wr(8'h04, cmd(2'h1, g, 2'h1, 1'b0, 1'b0));
    clr();
    wr(8'h04, cmd(2'h2, g, 2'h1, s, ac));
    settle(1);
    check((onAt[0] - rdAt[0] + 4) >> 3, rl + 1);
    check(offAt[0] - onAt[0], ch ? 16 : 32);
    expBeats += ch ? 8'h04 : 8'h08;
    apb(1'b0, 8'h08, 32'h0, q, e);
    check(q[15:8], expBeats);
    apb(1'b0, 8'h0C, 32'h0, q, e);
    check(q, {g, p, 1'b0, 3'h5, g, p, 1'b1, 3'h5,
              g, p + 2'h1, 1'b0, 3'h5, g, p + 2'h1, 1'b1, 3'h5});
    check(bankOpen[{g, 2'h1}], !ac);
  endtask

  task automatic resetValues;
    logic [31:0] q;
    logic        e;
    apb(1'b0, 8'h00, 32'h0, q, e);
    check(q, {23'h0, ddr_read_pkg::MODE_RESET});
    check(link.strobeWire, 1'b1);
    check(bankOpen, 16'h0);
    apb(1'b0, 8'h10, 32'h0, q, e);
    check(e, 1'b1);
    $display("reset values test done");
  endtask

  // Each burst field, both selects under field 01, auto close alternating
  task automatic burstModes;
    logic [1:0] f[4] = '{2'h0, 2'h1, 2'h1, 2'h2};
    logic       s[4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++)
      runOne(cfg(f[i], 1'b0, 1'b0), 2'(i), s[i], i[0], i > 1, 11);
    runOne(cfg(2'h0, 1'b0, 1'b1), 2'h1, 1'b1, 1'b0, 1'b0, 21);
    runOne(cfg(2'h0, 1'b1, 1'b0), 2'h2, 1'b1, 1'b1, 1'b0, 11);
    $display("burst mode test done");
  endtask

  // Two reads to other groups queued together go out four clocks apart
  task automatic backToBack(input logic ch);
    wr(8'h00, cfg(ch ? 2'h2 : 2'h0, 1'b0, 1'b0));
    clr();
    wr(8'h04, cmd(2'h2, 2'h0, 2'h0, 1'b1, 1'b0));
    wr(8'h04, cmd(2'h2, 2'h3, 2'h0, 1'b1, 1'b0));
    settle(ch ? 2 : 1);
    check((rdAt[1] - rdAt[0]) >> 3, 4);
    check(offAt[0] - onAt[0], ch ? 16 : 64);
    if (ch)
      check(onAt[1] - onAt[0], 32);
    expBeats += ch ? 8'h08 : 8'h10;
    $display("back to back test done");
  endtask

  // Same group pair: spacing five, or six under the long preamble
  task automatic spacing(input logic p2);
    logic [31:0] q;
    logic        e;
    wr(8'h00, cfg(2'h0, p2, 1'b0));
    clr();
    wr(8'h04, cmd(2'h2, 2'h2, 2'h0, 1'b1, 1'b0));
    wr(8'h04, cmd(2'h2, 2'h2, 2'h3, 1'b1, 1'b0));
    settle(2);
    check((rdAt[1] - rdAt[0]) >> 3, p2 ? 6 : 5);
    check(onAt[1] - onAt[0], p2 ? 48 : 40);
    expBeats += 8'h10;
    // Every beat of the earlier paired runs must have been captured
    apb(1'b0, 8'h08, 32'h0, q, e);
    check(q[15:8], expBeats);
    $display("spacing test done");
  endtask

  // Without a locked loop no data may appear; only data bus turn-on is counted
  task automatic unlocked;
    @(posedge clk);
    dllLocked <= 1'b0;
    wr(8'h00, cfg(2'h0, 1'b0, 1'b0));
    clr();
    wr(8'h04, cmd(2'h2, 2'h1, 2'h0, 1'b1, 1'b0));
    settle(1);
    check(nOn, 0);
    dllLocked <= 1'b1;
    $display("unlocked test done");
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    dllLocked = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {err_count, cmp_count, cyc, nRd, nOn, nOff} = '0;
    prevCmd = '0;
    prevDq = 1'b0;
    expBeats = 8'h00;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    resetValues();
    burstModes();
    backToBack(1'b0);
    backToBack(1'b1);
    spacing(1'b0);
    spacing(1'b1);
    unlocked();
    results();
  end
endmodule
`default_nettype wire
